// >>> tb_tri_port_bus_exchanger.sv
// self-checking bench of the three-port bus exchanger
// assumes tpx_pkg, tpx_exchanger and tpx_bus_partner compiled first
`default_nettype none
module tb_tri_port_bus_exchanger
  import tpx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] te = 3'h0, cc = 3'h0, ce_n = 3'h7, de_n = 3'h7, sel = 3'h0;
  logic [2:0] pdrv = 3'h0;
  logic [15:0] pv [3];
  logic [15:0] hm [3];
  wire logic [15:0] din [3];
  wire logic [15:0] dout [3];
  wire logic [2:0] oe;
  logic [4:0] awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int seed = 32'hf87d;
  int bad_count = 0;
  int comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  tpx_exchanger uut (.sys_clk(sys_clk), .rst(rst),
    .port_a_data_in(din[0]), .port_a_data_out(dout[0]),
    .port_a_data_oe(oe[0]), .port_b_data_in(din[1]),
    .port_b_data_out(dout[1]), .port_b_data_oe(oe[1]),
    .port_c_data_in(din[2]), .port_c_data_out(dout[2]),
    .port_c_data_oe(oe[2]), .port_a_drive_enable_n(de_n[0]),
    .port_b_drive_enable_n(de_n[1]), .port_c_drive_enable_n(de_n[2]),
    .port_a_source_select(sel[0]), .port_b_source_select(sel[1]),
    .port_c_source_select(sel[2]), .port_a_transparent_enable(te[0]),
    .port_b_transparent_enable(te[1]), .port_c_transparent_enable(te[2]),
    .port_a_capture_clock(cc[0]), .port_b_capture_clock(cc[1]),
    .port_c_capture_clock(cc[2]), .port_a_capture_enable_n(ce_n[0]),
    .port_b_capture_enable_n(ce_n[1]), .port_c_capture_enable_n(ce_n[2]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  tpx_bus_partner bus_a (.sys_clk(sys_clk), .drive(pdrv[0]), .value(pv[0]),
    .dev_out(dout[0]), .dev_oe(oe[0]), .bus(din[0]));
  tpx_bus_partner bus_b (.sys_clk(sys_clk), .drive(pdrv[1]), .value(pv[1]),
    .dev_out(dout[1]), .dev_oe(oe[1]), .bus(din[1]));
  tpx_bus_partner bus_c (.sys_clk(sys_clk), .drive(pdrv[2]), .value(pv[2]),
    .dev_out(dout[2]), .dev_oe(oe[2]), .bus(din[2]));

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pins pass two sync flops, a store and an output flop: 6 edges is ample
  // returns at a rising edge so the next inputs move on that edge
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask

  // ready is sampled at the falling edge: inputs only move after rising ones
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
      output logic [1:0] r);
    bit ta, tw, tb, done;
    done = 1'b0;
    // one edge apart from the last release, so nothing is driven twice
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge sys_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      done = tb;
    end
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
      output logic [1:0] r);
    bit ta, tr, done;
    done = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge sys_clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      done = tr;
    end
  endtask

  task automatic chk_held(input int p);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(5'(p * 4), d, r);
    check("held", d, {16'h0, hm[p]});
    check("held resp", 32'(r), 32'(TPX_RESP_OKAY));
  endtask

  function automatic logic [15:0] exp_out(input int p);
    case (p)
      0: exp_out = sel[0] ? hm[2] : hm[1];
      1: exp_out = sel[1] ? hm[0] : hm[2];
      default: exp_out = sel[2] ? hm[1] : hm[0];
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    foreach (pv[i]) begin
      pv[i] = 16'h0;
      hm[i] = 16'h0;
    end
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    chk_held(1);
    for (int p = 0; p < 3; p++) begin
      pdrv[p] <= 1'b1;
      te[p] <= 1'b1;
      pv[p] <= 16'($random(seed));
      settle();
      hm[p] = pv[p];
      chk_held(p);
      cc[p] <= 1'b1;
      pv[p] <= 16'($random(seed));
      settle();
      hm[p] = pv[p];
      chk_held(p);
      te[p] <= 1'b0;
      settle();
      pv[p] <= ~pv[p];
      settle();
      chk_held(p);
      ce_n[p] <= 1'b0;
      cc[p] <= 1'b0;
      settle();
      chk_held(p);
      cc[p] <= 1'b1;
      settle();
      hm[p] = pv[p];
      chk_held(p);
      ce_n[p] <= 1'b1;
      cc[p] <= 1'b0;
      settle();
      pv[p] <= 16'($random(seed));
      cc[p] <= 1'b1;
      settle();
      chk_held(p);
      pdrv[p] <= 1'b0;
    end
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      // first pass puts the A storage on both B and C
      if (i == 0) d[5:0] = 6'h10;
      de_n <= d[2:0];
      sel <= d[5:3];
      settle();
      for (int p = 0; p < 3; p++) begin
        check("oe", 32'(oe[p]), 32'(!de_n[p]));
        if (!de_n[p]) check("out", 32'(dout[p]), 32'(exp_out(p)));
      end
      axi_rd(TPX_REG_PINS, d, r);
      check("pins", d, {23'h0, sel, te, ~de_n});
    end
    de_n <= 3'h0;
    axi_wr(TPX_REG_CTRL, 32'h1, r);
    check("ctrl resp", 32'(r), 32'(TPX_RESP_OKAY));
    settle();
    check("blocked oe", 32'(oe), 32'h0);
    axi_rd(TPX_REG_CTRL, d, r);
    check("ctrl", d, 32'h1);
    axi_wr(TPX_REG_CTRL, 32'h0, r);
    axi_wr(TPX_REG_HELD_A, 32'hffff, r);
    check("ro write", 32'(r), 32'(TPX_RESP_SLVERR));
    axi_rd(5'h14, d, r);
    check("unmapped", 32'(r), 32'(TPX_RESP_SLVERR));
    settle();
    check("open oe", 32'(oe), 32'h7);
    chk_held(0);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> tpx_bus_partner.sv
// model of the outside logic on one 16-bit port bus
// assumes the device pin is split into data out, data in and one enable
`default_nettype none
module tpx_bus_partner
  import tpx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic drive,
  input wire logic [TPX_DATA_W-1:0] value,
  input wire logic [TPX_DATA_W-1:0] dev_out,
  input wire logic dev_oe,
  output logic [TPX_DATA_W-1:0] bus
);
  logic [TPX_DATA_W-1:0] last = '0;

  // nobody driving: no stale level, the bus flips every cycle
  always_comb begin
    if (dev_oe) begin
      bus = dev_out;
    end else if (drive) begin
      bus = value;
    end else begin
      bus = ~last;
    end
  end

  always_ff @(posedge sys_clk) begin
    last <= bus;
  end
endmodule
`default_nettype wire

// >>> tpx_exchanger.sv
// three-port 16-bit bus exchanger with AXI4-Lite status and control
// assumes port pins are asynchronous and pass a two-flop synchroniser
`default_nettype none
module tpx_exchanger
  import tpx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [TPX_DATA_W-1:0] port_a_data_in,
  output logic [TPX_DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe,
  input wire logic [TPX_DATA_W-1:0] port_b_data_in,
  output logic [TPX_DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe,
  input wire logic [TPX_DATA_W-1:0] port_c_data_in,
  output logic [TPX_DATA_W-1:0] port_c_data_out,
  output logic port_c_data_oe,
  input wire logic port_a_drive_enable_n,
  input wire logic port_b_drive_enable_n,
  input wire logic port_c_drive_enable_n,
  input wire logic port_a_source_select,
  input wire logic port_b_source_select,
  input wire logic port_c_source_select,
  input wire logic port_a_transparent_enable,
  input wire logic port_b_transparent_enable,
  input wire logic port_c_transparent_enable,
  input wire logic port_a_capture_clock,
  input wire logic port_b_capture_clock,
  input wire logic port_c_capture_clock,
  input wire logic port_a_capture_enable_n,
  input wire logic port_b_capture_enable_n,
  input wire logic port_c_capture_enable_n,
  input wire logic [TPX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [TPX_AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [TPX_AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TPX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [TPX_AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  tpx_pin_t pin_raw [TPX_PORTS];
  tpx_pin_t pin_meta [TPX_PORTS];
  tpx_pin_t pin_s [TPX_PORTS];
  logic [TPX_DATA_W-1:0] held [TPX_PORTS];
  logic [TPX_DATA_W-1:0] drive_data [TPX_PORTS];
  logic [TPX_DATA_W-1:0] next_drive_data [TPX_PORTS];
  logic [TPX_PORTS-1:0] drive_oe;
  logic [TPX_PORTS-1:0] next_drive_oe;
  logic block_drive;

  assign pin_raw[0] = '{ctrl: '{port_a_transparent_enable,
    port_a_capture_clock, port_a_capture_enable_n,
    port_a_drive_enable_n, port_a_source_select}, data: port_a_data_in};
  assign pin_raw[1] = '{ctrl: '{port_b_transparent_enable,
    port_b_capture_clock, port_b_capture_enable_n,
    port_b_drive_enable_n, port_b_source_select}, data: port_b_data_in};
  assign pin_raw[2] = '{ctrl: '{port_c_transparent_enable,
    port_c_capture_clock, port_c_capture_enable_n,
    port_c_drive_enable_n, port_c_source_select}, data: port_c_data_in};

  // pins are asynchronous: meta stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    pin_meta <= pin_raw;
    pin_s <= pin_meta;
  end

  for (genvar i = 0; i < TPX_PORTS; i++) begin : g_port
    localparam int HI = (i + 2) % TPX_PORTS;
    localparam int LO = (i + 1) % TPX_PORTS;

    // one element per port, each on its own controls
    tpx_store #(.W(TPX_DATA_W)) u_store (
      .sys_clk(sys_clk),
      .rst(rst),
      .data(pin_s[i].data),
      .transparent_enable(pin_s[i].ctrl.transparent_enable),
      .capture_clock(pin_s[i].ctrl.capture_clock),
      .capture_enable_n(pin_s[i].ctrl.capture_enable_n),
      .held(held[i])
    );

    always_comb begin
      // any storage may feed several ports at once
      next_drive_data[i] = pin_s[i].ctrl.source_select ? held[HI]
                                                       : held[LO];
      next_drive_oe[i] = !pin_s[i].ctrl.drive_enable_n && !block_drive;
    end

    property p_select;
      pin_s[i].ctrl.source_select |=> drive_data[i] == $past(held[HI]);
    endproperty
    a_select: assert property (@(posedge sys_clk) disable iff (rst)
      p_select) else $error("port did not drive selected storage");

    property p_drive_off;
      pin_s[i].ctrl.drive_enable_n |=> !drive_oe[i];
    endproperty
    a_drive_off: assert property (@(posedge sys_clk) disable iff (rst)
      p_drive_off) else $error("port drove with enable high");
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_oe <= '0;
      for (int i = 0; i < TPX_PORTS; i++) begin
        drive_data[i] <= '0;
      end
    end else begin
      drive_oe <= next_drive_oe;
      drive_data <= next_drive_data;
    end
  end

  assign port_a_data_out = drive_data[0];
  assign port_b_data_out = drive_data[1];
  assign port_c_data_out = drive_data[2];
  assign port_a_data_oe = drive_oe[0];
  assign port_b_data_oe = drive_oe[1];
  assign port_c_data_oe = drive_oe[2];

  property p_shared_source;
    (pin_s[1].ctrl.source_select && !pin_s[2].ctrl.source_select)
      |=> port_b_data_out == port_c_data_out;
  endproperty
  a_shared_source: assert property (@(posedge sys_clk) disable iff (rst)
    p_shared_source) else $error("shared source differs on two ports");

  // ---- AXI4-Lite slave
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [TPX_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [TPX_AXI_DATA_W-1:0] w_data, next_w_data;
  logic [TPX_AXI_STRB_W-1:0] w_strb, next_w_strb;
  logic next_bvalid, next_block_drive;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [TPX_AXI_DATA_W-1:0] next_rdata;

  // single outstanding write and read; address and data in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_block_drive = block_drive;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = TPX_RESP_SLVERR;
      if (aw_addr == TPX_REG_CTRL) begin
        next_bresp = TPX_RESP_OKAY;
        if (w_strb[0]) begin
          next_block_drive = w_data[TPX_CTRL_BLOCK_BIT];
        end
      end
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = TPX_RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        TPX_REG_HELD_A: next_rdata[TPX_DATA_W-1:0] = held[0];
        TPX_REG_HELD_B: next_rdata[TPX_DATA_W-1:0] = held[1];
        TPX_REG_HELD_C: next_rdata[TPX_DATA_W-1:0] = held[2];
        TPX_REG_CTRL: next_rdata[TPX_CTRL_BLOCK_BIT] = block_drive;
        TPX_REG_PINS: begin
          for (int i = 0; i < TPX_PORTS; i++) begin
            next_rdata[TPX_PINS_DRIVE_LSB + i] = drive_oe[i];
            next_rdata[TPX_PINS_TRANSP_LSB + i] =
              pin_s[i].ctrl.transparent_enable;
            next_rdata[TPX_PINS_SELECT_LSB + i] = pin_s[i].ctrl.source_select;
          end
        end
        default: next_rresp = TPX_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TPX_RESP_OKAY;
      block_drive <= TPX_CTRL_BLOCK_RESET;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= TPX_RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      block_drive <= next_block_drive;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// >>> tpx_pkg.sv
// shared constants and types of the three-port bus exchanger
// assumes a single sys_clk domain and a 32-bit AXI4-Lite register bus
`default_nettype none
package tpx_pkg;
  localparam int TPX_DATA_W = 16;
  localparam int TPX_PORTS = 3;
  localparam int TPX_ADDR_W = 5;
  localparam int TPX_AXI_DATA_W = 32;
  localparam int TPX_AXI_STRB_W = 4;
  // register byte addresses
  localparam logic [4:0] TPX_REG_HELD_A = 5'h00;
  localparam logic [4:0] TPX_REG_HELD_B = 5'h04;
  localparam logic [4:0] TPX_REG_HELD_C = 5'h08;
  localparam logic [4:0] TPX_REG_CTRL = 5'h0c;
  localparam logic [4:0] TPX_REG_PINS = 5'h10;
  // control register fields
  localparam int TPX_CTRL_BLOCK_BIT = 0;
  localparam logic TPX_CTRL_BLOCK_RESET = 1'b0;
  // pin status register fields
  localparam int TPX_PINS_DRIVE_LSB = 0;
  localparam int TPX_PINS_TRANSP_LSB = 3;
  localparam int TPX_PINS_SELECT_LSB = 6;
  localparam logic [1:0] TPX_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPX_RESP_SLVERR = 2'h2;
  localparam logic TPX_CLK_PREV_RESET = 1'b1;

  typedef struct packed {
    logic transparent_enable;
    logic capture_clock;
    logic capture_enable_n;
    logic drive_enable_n;
    logic source_select;
  } tpx_pin_ctrl_t;

  typedef struct packed {
    tpx_pin_ctrl_t ctrl;
    logic [TPX_DATA_W-1:0] data;
  } tpx_pin_t;
endpackage
`default_nettype wire

// >>> tpx_store.sv
// one port storage element: transparent, held or edge captured
// assumes all inputs already synchronised to sys_clk
`default_nettype none
module tpx_store
  import tpx_pkg::*;
#(
  parameter int W = TPX_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] data,
  input wire logic transparent_enable,
  input wire logic capture_clock,
  input wire logic capture_enable_n,
  output logic [W-1:0] held
);
  logic clk_prev;
  logic next_clk_prev;
  logic [W-1:0] next_held;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_comb begin
    next_clk_prev = capture_clock;
    next_held = held;
    if (transparent_enable) begin
      next_held = data;
    end else if (!capture_enable_n && capture_clock && !clk_prev) begin
      next_held = data;
    end
    // otherwise hold: no rising clock edge or disabled capture
  end

  // clk_prev resets high so a clock already high at release is no edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held <= '0;
      clk_prev <= TPX_CLK_PREV_RESET;
    end else begin
      held <= next_held;
      clk_prev <= next_clk_prev;
    end
  end

  property p_transparent;
    transparent_enable |=> held == $past(data);
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("transparent element did not follow input");

  property p_steady_hold;
    (!transparent_enable && capture_clock == $past(capture_clock))
      |=> held == $past(held);
  endproperty
  a_steady_hold: assert property (p_steady_hold)
    else $error("held value changed with steady clock");

  // clk_prev resets high, so no edge counts on the first cycle after reset
  property p_edge_capture;
    (!transparent_enable && !capture_enable_n && $rose(capture_clock)
      && !$past(rst)) |=> held == $past(data);
  endproperty
  a_edge_capture: assert property (p_edge_capture)
    else $error("rising edge did not capture input");

  property p_disabled_hold;
    (!transparent_enable && capture_enable_n) |=> $stable(held);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("disabled capture changed held value");
endmodule
`default_nettype wire
